/* inc/dfv_pkg.sv */
// Constants for the descriptor field validator: register map, field
// positions, attribute encodings, packet size limits and error codes.
// Assumes one core clock and a simple strobe register port in front.
//
// Overview of operation
// R01 - Transfer type bits 1..0, sync 3..2
// R02 - Usage bits 5..4: data, feedback, implicit
// R03 - Non-isochronous endpoints keep bits 5..2 zero
// R04 - Explicit feedback: isochronous, no synchronization
// R05 - Feedback runs opposite to its data endpoints
// R06 - Group ascending; lowest shares feedback number
// R07 - Data picks first feedback numbered at/below
// R08 - High-speed bits 12..11 give extra transactions
// R09 - Packet size range set by transaction count
// R10 - Host may ignore bulk OUT interval
// R11 - No strings: every string index zero
// R12 - Index zero returns language list at 2
// R13 - No strings: no language list returned
// R14 - Language list unterminated, size first byte minus 2
// R15 - String: length, type, characters from 2
// R16 - Requester names language with sixteen-bit ID
// R17 - Extended descriptors start with length byte
// R18 - One error flag, latched broken rule code
package dfv_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] DFV_OFF_CTRL = 8'h00; // Control
	localparam logic [7:0] DFV_OFF_STATUS = 8'h04; // Status
	localparam logic [7:0] DFV_OFF_EP_SEL = 8'h08; // Slot select
	localparam logic [7:0] DFV_OFF_EP_ATTR = 8'h0C; // Slot attributes
	localparam logic [7:0] DFV_OFF_EP_MPS = 8'h10; // Slot packet size
	localparam logic [7:0] DFV_OFF_WORD = 8'h14; // Word store
	localparam logic [7:0] DFV_OFF_STR_REQ = 8'h18; // String request
	localparam logic [7:0] DFV_OFF_STR_DATA = 8'h1C; // String bytes
	localparam logic [7:0] DFV_OFF_IDX_CHK = 8'h20; // Index check
	localparam logic [7:0] DFV_OFF_EXT_HDR = 8'h24; // Extended header

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DFV_CTRL_STR_EN = 0; // Strings supported
	localparam int DFV_CTRL_START = 1; // Start table scan
	localparam int DFV_CTRL_CLR = 2; // Clear error latch
	localparam int DFV_CTRL_NLANG = 4; // Language count, 4 bits
	localparam int DFV_ST_ERR = 0; // Error flag
	localparam int DFV_ST_BUSY = 1; // Scan running
	localparam int DFV_ST_DONE = 2; // Scan finished
	localparam int DFV_ST_NODESC = 3; // No descriptor to give
	localparam int DFV_ST_SLOT = 4; // Failing slot, 3 bits
	localparam int DFV_ST_CODE = 8; // Error code, 5 bits
	localparam int DFV_EA_NUM = 8; // Endpoint number, 4 bits
	localparam int DFV_EA_DIR = 12; // Direction, 1 = IN
	localparam int DFV_EA_HS = 13; // High-speed endpoint
	localparam int DFV_EA_VLD = 14; // Slot in use
	localparam int DFV_WD_IDX = 16; // Word index, 3 bits
	localparam int DFV_SR_CNT = 8; // Character count, 6 bits
	localparam int DFV_SR_LANG = 16; // Language ID, 16 bits

	// ----------------------------------------------------------------
	// Attribute and packet size encodings
	// ----------------------------------------------------------------
	localparam int DFV_SLOTS = 8; // Endpoint table depth
	localparam logic [1:0] DFV_TT_ISO = 2'h1; // Isochronous
	localparam logic [1:0] DFV_TT_INT = 2'h3; // Interrupt
	localparam logic [1:0] DFV_SY_NONE = 2'h0; // No synchronization
	localparam logic [1:0] DFV_SY_ASYNC = 2'h1; // Asynchronous
	localparam logic [1:0] DFV_SY_ADAPT = 2'h2; // Adaptive
	localparam logic [1:0] DFV_UT_DATA = 2'h0; // Plain data
	localparam logic [1:0] DFV_UT_FB = 2'h1; // Explicit feedback
	localparam logic [1:0] DFV_UT_IMPL = 2'h2; // Implicit feedback
	localparam logic [1:0] DFV_UT_RSVD = 2'h3; // Reserved usage
	localparam logic [1:0] DFV_MULT_RSVD = 2'h3; // Reserved count
	localparam logic [10:0] DFV_MPS_MIN0 = 11'h001; // One transaction
	localparam logic [10:0] DFV_MPS_MIN1 = 11'h201; // Two: 513
	localparam logic [10:0] DFV_MPS_MIN2 = 11'h2AB; // Three: 683
	localparam logic [10:0] DFV_MPS_MAX = 11'h400; // Upper bound 1024

	// ----------------------------------------------------------------
	// String descriptor layout
	// ----------------------------------------------------------------
	localparam logic [7:0] DFV_HDR_BYTES = 8'h02; // Length plus type
	localparam logic [7:0] DFV_TYPE_STRING = 8'h03; // String type code

	// ----------------------------------------------------------------
	// Error codes: the number of the broken constraint
	// ----------------------------------------------------------------
	localparam logic [4:0] DFV_E_RSVD = 5'h01; // Reserved attr bits
	localparam logic [4:0] DFV_E_USAGE = 5'h02; // Reserved usage
	localparam logic [4:0] DFV_E_NONISO = 5'h03; // Bits 5..2 set
	localparam logic [4:0] DFV_E_FBTYPE = 5'h04; // Bad feedback type
	localparam logic [4:0] DFV_E_FBDIR = 5'h05; // No feedback found
	localparam logic [4:0] DFV_E_GROUP = 5'h06; // Group head missing
	localparam logic [4:0] DFV_E_MULT = 5'h08; // Bad count bits
	localparam logic [4:0] DFV_E_SIZE = 5'h09; // Size out of range
	localparam logic [4:0] DFV_E_STRIDX = 5'h0B; // Index without strings
	localparam logic [4:0] DFV_E_EXTLEN = 5'h11; // Bad length byte

	// Scan state machine
	typedef enum logic [1:0] {
		DFV_IDLE = 2'b01,
		DFV_SCAN = 2'b10
	} dfv_state_t;

endpackage

/* inc/dfv_tbl_if.sv */
// Endpoint table view shared between the validator and the search.
// Assumes both ends sit in the core clock domain; purely combinational.
`timescale 1ns/1ps
interface dfv_tbl_if;
	logic [7:0] vld; // Slot in use
	logic [7:0] dir_in; // Slot direction, 1 = IN
	logic [7:0] fb_src; // Slot gives feedback
	logic [7:0] iso_data; // Slot is isochronous data
	logic [7:0][3:0] num; // Endpoint numbers
	logic [3:0] q_num; // Query endpoint number
	logic q_dir; // Query direction
	logic hit; // Feedback endpoint found
	logic [3:0] fb_num; // Its endpoint number
	logic head_ok; // Group head present

	modport owner(output vld, dir_in, fb_src, iso_data, num, q_num,
		q_dir, input hit, fb_num, head_ok);
	modport search(input vld, dir_in, fb_src, iso_data, num, q_num,
		q_dir, output hit, fb_num, head_ok);
endinterface

/* logic/dfv_fb_search.sv */
// Feedback endpoint search over the endpoint table.
// Assumes the owner presents a stable table and query each cycle.
`timescale 1ns/1ps
module dfv_fb_search
	import dfv_pkg::*;
(
	dfv_tbl_if.search tbl // Table and query
);

	// ----------------------------------------------------------------
	// Search
	// ----------------------------------------------------------------
	logic hit_c; // Found flag
	logic [3:0] fbn_c; // Best feedback number
	logic head_c; // Head found

	// Closest feedback at or below the query, opposite direction
	always_comb begin
		hit_c = 1'b0;
		fbn_c = 4'h0;
		head_c = 1'b0;
		for (int i = 0; i < DFV_SLOTS; i++) begin
			// Highest number not above own is the first one met
			if (tbl.vld[i] && tbl.fb_src[i] && // R07
				(tbl.dir_in[i] != tbl.q_dir) && // R05
				(tbl.num[i] <= tbl.q_num) &&
				(!hit_c || tbl.num[i] > fbn_c)) begin
				hit_c = 1'b1;
				fbn_c = tbl.num[i];
			end
		end
		// Lowest data endpoint of the group shares the number
		for (int i = 0; i < DFV_SLOTS; i++) begin
			if (hit_c && tbl.vld[i] && tbl.iso_data[i] &&
				(tbl.dir_in[i] == tbl.q_dir) &&
				(tbl.num[i] == fbn_c)) begin
				head_c = 1'b1; // R06
			end
		end
	end

	assign tbl.hit = hit_c;
	assign tbl.fb_num = fbn_c;
	assign tbl.head_ok = head_c;

endmodule

/* logic/dfv_validator.sv */
// Descriptor field validator: endpoint table checks, string forming.
// Assumes a strobe register port, read data one cycle after the strobe,
// and a single core clock with synchronous active-high reset.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module dfv_validator
	import dfv_pkg::*;
(
	input wire logic core_clk, // Core clock, 40 MHz
	input wire logic rst, // Synchronous reset, high
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, next cycle
	output logic err_flag, // Latched error
	output logic scan_busy // Table scan running
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dfv_state_t fsm; // Scan state
		logic [2:0] idx; // Slot under scan
		logic err; // Error latch
		logic [4:0] code; // Broken constraint
		logic [2:0] eslot; // Slot that failed
		logic done; // Scan finished
		logic str_en; // Strings supported
		logic [3:0] nlang; // Language count
		logic [2:0] sel; // Selected slot
		logic [7:0] vld; // Slot in use
		logic [7:0] dir; // Slot direction
		logic [7:0] hs; // Slot high speed
		logic [7:0][7:0] attr; // Attribute bytes
		logic [7:0][3:0] num; // Endpoint numbers
		logic [7:0][15:0] mps; // Packet size words
		logic [7:0][15:0] words; // Language or character store
		logic [7:0] sidx; // Requested string index
		logic [5:0] scnt; // Character count
		logic [7:0] ptr; // Byte pointer
		logic nodesc; // Nothing to return
		logic [31:0] rdata; // Read data
	} dfv_regs_t;

	localparam dfv_regs_t DFV_REGS_RST = '{fsm: DFV_IDLE, default: '0};

	dfv_regs_t dfv_r; // Registered state
	dfv_regs_t dfv_nxt; // Next state

	dfv_tbl_if tbl(); // Table view for the search

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Attribute and packet size encoding check; zero when clean
	function automatic logic [4:0] attr_code(
		input logic [7:0] bm,
		input logic hs,
		input logic [15:0] mps
	);
		logic [1:0] tt;
		logic [1:0] sy;
		logic [1:0] ut;
		logic [1:0] mult;
		logic [10:0] size;
		logic [10:0] lo;
		tt = bm[1:0]; // R01
		sy = bm[3:2]; // R01
		ut = bm[5:4]; // R02
		mult = mps[12:11]; // R08
		size = mps[10:0];
		unique case (mult)
			2'h0: lo = DFV_MPS_MIN0;
			2'h1: lo = DFV_MPS_MIN1;
			default: lo = DFV_MPS_MIN2;
		endcase
		attr_code = 5'h00;
		if (bm[7:6] != 2'h0) begin
			attr_code = DFV_E_RSVD; // R01
		end else if (tt != DFV_TT_ISO && bm[5:2] != 4'h0) begin
			attr_code = DFV_E_NONISO; // R03
		end else if (ut == DFV_UT_RSVD) begin
			attr_code = DFV_E_USAGE; // R02
		end else if (ut == DFV_UT_FB &&
			(tt != DFV_TT_ISO || sy != DFV_SY_NONE)) begin
			attr_code = DFV_E_FBTYPE; // R04
		end else if (hs && (tt == DFV_TT_ISO || tt == DFV_TT_INT)) begin
			// Only periodic high-speed endpoints use the count bits
			if (mult == DFV_MULT_RSVD || mps[15:13] != 3'h0) begin
				attr_code = DFV_E_MULT; // R08
			end else if (size < lo || size > DFV_MPS_MAX) begin
				attr_code = DFV_E_SIZE; // R09
			end
		end
	endfunction

	// Isochronous slot, whatever its usage class
	function automatic logic is_iso(input logic [7:0] bm);
		is_iso = (bm[1:0] == DFV_TT_ISO);
	endfunction

	// ----------------------------------------------------------------
	// Table view for the feedback search
	// ----------------------------------------------------------------

	// Implicit feedback slots count as both feedback and data
	always_comb begin
		tbl.vld = dfv_r.vld;
		tbl.dir_in = dfv_r.dir;
		tbl.num = dfv_r.num;
		for (int i = 0; i < DFV_SLOTS; i++) begin
			tbl.fb_src[i] = is_iso(dfv_r.attr[i]) &&
				(dfv_r.attr[i][5:4] == DFV_UT_FB ||
				dfv_r.attr[i][5:4] == DFV_UT_IMPL);
			tbl.iso_data[i] = is_iso(dfv_r.attr[i]) &&
				(dfv_r.attr[i][5:4] == DFV_UT_DATA ||
				dfv_r.attr[i][5:4] == DFV_UT_IMPL);
		end
		tbl.q_num = dfv_r.num[dfv_r.idx];
		tbl.q_dir = dfv_r.dir[dfv_r.idx];
	end

	dfv_fb_search u_search (
		.tbl(tbl.search)
	);

	// ----------------------------------------------------------------
	// String descriptor byte former
	// ----------------------------------------------------------------
	logic [5:0] cnt; // Words in the descriptor
	logic [7:0] blen; // First byte of the descriptor
	logic [7:0] woff; // Offset past the header
	logic [15:0] wsel; // Addressed word
	logic [7:0] sbyte; // Byte at the pointer

	// Index zero lists languages, others list characters
	always_comb begin
		cnt = (dfv_r.sidx == 8'h00) ? {2'h0, dfv_r.nlang} : dfv_r.scnt;
		blen = DFV_HDR_BYTES + {1'b0, cnt, 1'b0}; // R14 R15
		woff = dfv_r.ptr - DFV_HDR_BYTES;
		wsel = dfv_r.words[woff[3:1]];
		if (dfv_r.nodesc || dfv_r.ptr >= blen) begin
			sbyte = 8'h00; // R13
		end else if (dfv_r.ptr == 8'h00) begin
			sbyte = blen; // R15
		end else if (dfv_r.ptr == 8'h01) begin
			sbyte = DFV_TYPE_STRING; // R15
		end else if (woff[7:4] != 4'h0) begin
			// Store holds eight words; longer strings read zero
			sbyte = 8'h00;
		end else begin
			// Low byte first, payload from byte 2, no terminator
			sbyte = woff[0] ? wsel[15:8] : wsel[7:0]; // R12 R14
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic [4:0] scan_code; // Error from the scan
	logic [4:0] wr_code; // Error from a checked write
	logic [4:0] new_code; // Error raised this cycle
	logic needs_fb; // Slot needs a feedback endpoint
	logic clr; // Software clears the latch
	logic [7:0] sattr; // Attribute of the scanned slot

	always_comb begin
		dfv_nxt = dfv_r;
		scan_code = 5'h00;
		wr_code = 5'h00;
		sattr = dfv_r.attr[dfv_r.idx];
		// Asynchronous OUT and adaptive IN data need a feedback pipe
		needs_fb = is_iso(sattr) && sattr[5:4] != DFV_UT_FB &&
			((sattr[3:2] == DFV_SY_ASYNC && !dfv_r.dir[dfv_r.idx]) ||
			(sattr[3:2] == DFV_SY_ADAPT && dfv_r.dir[dfv_r.idx]));
		clr = reg_wr && reg_addr == DFV_OFF_CTRL &&
			reg_wdata[DFV_CTRL_CLR];

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				DFV_OFF_CTRL: begin
					dfv_nxt.str_en = reg_wdata[DFV_CTRL_STR_EN];
					dfv_nxt.nlang = reg_wdata[DFV_CTRL_NLANG +: 4];
					// Start is ignored while a scan runs
					if (reg_wdata[DFV_CTRL_START] &&
						dfv_r.fsm == DFV_IDLE) begin
						dfv_nxt.fsm = DFV_SCAN;
						dfv_nxt.idx = 3'h0;
						dfv_nxt.done = 1'b0;
					end
				end
				DFV_OFF_EP_SEL: begin
					dfv_nxt.sel = reg_wdata[2:0];
				end
				DFV_OFF_EP_ATTR: begin
					dfv_nxt.attr[dfv_r.sel] = reg_wdata[7:0];
					dfv_nxt.num[dfv_r.sel] = reg_wdata[DFV_EA_NUM +: 4];
					dfv_nxt.dir[dfv_r.sel] = reg_wdata[DFV_EA_DIR];
					dfv_nxt.hs[dfv_r.sel] = reg_wdata[DFV_EA_HS];
					dfv_nxt.vld[dfv_r.sel] = reg_wdata[DFV_EA_VLD];
				end
				DFV_OFF_EP_MPS: begin
					dfv_nxt.mps[dfv_r.sel] = reg_wdata[15:0];
				end
				DFV_OFF_WORD: begin
					dfv_nxt.words[reg_wdata[DFV_WD_IDX +: 3]] =
						reg_wdata[15:0];
				end
				DFV_OFF_STR_REQ: begin
					// Language ID is accepted; one table serves all
					dfv_nxt.sidx = reg_wdata[7:0]; // R16
					dfv_nxt.scnt = reg_wdata[DFV_SR_CNT +: 6];
					dfv_nxt.ptr = 8'h00;
					dfv_nxt.nodesc = !dfv_r.str_en; // R13
				end
				DFV_OFF_IDX_CHK: begin
					if (!dfv_r.str_en && reg_wdata[7:0] != 8'h00) begin
						wr_code = DFV_E_STRIDX; // R11
					end
				end
				DFV_OFF_EXT_HDR: begin
					// Length byte must cover at least itself and type
					if (reg_wdata[7:0] < DFV_HDR_BYTES) begin
						wr_code = DFV_E_EXTLEN; // R17
					end
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end

		// Table scan, one slot a cycle
		unique case (dfv_r.fsm)
			DFV_IDLE: begin
				// Waiting for a start
			end
			DFV_SCAN: begin
				if (dfv_r.vld[dfv_r.idx]) begin
					scan_code = attr_code(sattr, dfv_r.hs[dfv_r.idx],
						dfv_r.mps[dfv_r.idx]);
					if (scan_code == 5'h00 && needs_fb) begin
						if (!tbl.hit) begin
							scan_code = DFV_E_FBDIR; // R05 R07
						end else if (!tbl.head_ok) begin
							scan_code = DFV_E_GROUP; // R06
						end
					end
				end
				dfv_nxt.idx = dfv_r.idx + 3'h1;
				if (dfv_r.idx == 3'h7) begin
					dfv_nxt.fsm = DFV_IDLE;
					dfv_nxt.done = 1'b1;
				end
			end
		endcase

		// Error latch: first error held, a new one beats the clear
		new_code = (scan_code != 5'h00) ? scan_code : wr_code;
		if (clr) begin
			// Wipe code and slot too, so a clean status reads zero
			dfv_nxt.err = 1'b0;
			dfv_nxt.code = 5'h00;
			dfv_nxt.eslot = 3'h0;
		end
		if (new_code != 5'h00 && (!dfv_r.err || clr)) begin
			dfv_nxt.err = 1'b1; // R18
			dfv_nxt.code = new_code; // R18
			dfv_nxt.eslot = (scan_code != 5'h00) ? dfv_r.idx : 3'h0;
		end

		// Register reads, answered next cycle
		dfv_nxt.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				DFV_OFF_CTRL: begin
					dfv_nxt.rdata[DFV_CTRL_STR_EN] = dfv_r.str_en;
					dfv_nxt.rdata[DFV_CTRL_NLANG +: 4] = dfv_r.nlang;
				end
				DFV_OFF_STATUS: begin
					dfv_nxt.rdata[DFV_ST_ERR] = dfv_r.err;
					dfv_nxt.rdata[DFV_ST_BUSY] = dfv_r.fsm == DFV_SCAN;
					dfv_nxt.rdata[DFV_ST_DONE] = dfv_r.done;
					dfv_nxt.rdata[DFV_ST_NODESC] = dfv_r.nodesc;
					dfv_nxt.rdata[DFV_ST_SLOT +: 3] = dfv_r.eslot;
					dfv_nxt.rdata[DFV_ST_CODE +: 5] = dfv_r.code;
				end
				DFV_OFF_EP_SEL: begin
					dfv_nxt.rdata[2:0] = dfv_r.sel;
				end
				DFV_OFF_EP_ATTR: begin
					dfv_nxt.rdata[7:0] = dfv_r.attr[dfv_r.sel];
					dfv_nxt.rdata[DFV_EA_NUM +: 4] = dfv_r.num[dfv_r.sel];
					dfv_nxt.rdata[DFV_EA_DIR] = dfv_r.dir[dfv_r.sel];
					dfv_nxt.rdata[DFV_EA_HS] = dfv_r.hs[dfv_r.sel];
					dfv_nxt.rdata[DFV_EA_VLD] = dfv_r.vld[dfv_r.sel];
				end
				DFV_OFF_EP_MPS: begin
					dfv_nxt.rdata[15:0] = dfv_r.mps[dfv_r.sel];
				end
				DFV_OFF_STR_REQ: begin
					dfv_nxt.rdata[7:0] = dfv_r.sidx;
					dfv_nxt.rdata[DFV_SR_CNT +: 6] = dfv_r.scnt;
				end
				DFV_OFF_STR_DATA: begin
					// Each read moves the pointer on; it stops at the top
					dfv_nxt.rdata[7:0] = sbyte;
					if (dfv_r.ptr != 8'hFF) begin
						dfv_nxt.ptr = dfv_r.ptr + 8'h01;
					end
				end
				default: begin
					// Unmapped and write-only offsets read zero
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dfv_r <= DFV_REGS_RST;
		end else begin
			dfv_r <= dfv_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = dfv_r.rdata;
	assign err_flag = dfv_r.err;
	assign scan_busy = (dfv_r.fsm == DFV_SCAN);

endmodule

/* tb/dfv_checker_sva.sv */
// Checker for the validator's register port and flags.
// Assumes the top-level port set and one core clock.
`timescale 1ns/1ps
module dfv_checker
	import dfv_pkg::*;
(
	input wire logic core_clk, // Core clock
	input wire logic rst, // Sync reset
	input wire logic [7:0] reg_addr, // Address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic err_flag, // Error latch
	input wire logic scan_busy // Scan running
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------
	// Shadow of control bits and string pointer
	// ------------------------------------------------
	logic str_en_r; // Strings on
	logic [3:0] nlang_r; // Language count
	logic [5:0] cnt_r; // Count of request
	logic ok_r; // Descriptor present
	logic [7:0] ptr_r; // Byte pointer
	wire ctl_wr = reg_wr && reg_addr == DFV_OFF_CTRL; // Control write
	wire clr_wr = ctl_wr && reg_wdata[DFV_CTRL_CLR]; // Error clear
	wire start_ok = ctl_wr && reg_wdata[DFV_CTRL_START] && !scan_busy;
	wire req_wr = reg_wr && reg_addr == DFV_OFF_STR_REQ; // New request
	wire dat_rd = reg_rd && reg_addr == DFV_OFF_STR_DATA; // Byte read
	// Mirrors only what a port-level view can know
	always_ff @(posedge core_clk) begin
		if (rst) begin
			str_en_r <= 1'b0;
			nlang_r <= 4'h0;
			cnt_r <= 6'h00;
			ok_r <= 1'b0;
			ptr_r <= 8'h00;
		end else if (ctl_wr) begin
			str_en_r <= reg_wdata[DFV_CTRL_STR_EN];
			nlang_r <= reg_wdata[7:4];
		end else if (req_wr) begin
			cnt_r <= (reg_wdata[7:0] == 8'h00) ? {2'h0, nlang_r}
				: reg_wdata[13:8];
			ok_r <= str_en_r;
			ptr_r <= 8'h00;
		end else if (dat_rd && ptr_r != 8'hFF) begin
			ptr_r <= ptr_r + 8'h01; // Saturates like the design
		end
	end
	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	a_busy_span: assert property (start_ok |=> scan_busy [*8] ##1 !scan_busy)
		else $error("scan busy span wrong");
	a_busy_cause: assert property ($rose(scan_busy) |-> $past(start_ok))
		else $error("scan began without start");
	a_err_sticky: assert property (err_flag && !clr_wr |=> err_flag)
		else $error("error latch dropped");
	a_err_clear: assert property (clr_wr && !scan_busy
		&& !reg_wdata[DFV_CTRL_START] |=> !err_flag)
		else $error("error latch not cleared");
	a_idx_error: assert property (reg_wr && reg_addr == DFV_OFF_IDX_CHK
		&& reg_wdata[7:0] != 8'h00 && !str_en_r |=> err_flag)
		else $error("string index not flagged");
	a_ext_length: assert property (reg_wr && reg_addr == DFV_OFF_EXT_HDR
		&& reg_wdata[7:0] < 8'h02 |=> err_flag)
		else $error("short length byte not flagged");
	a_str_len: assert property (dat_rd && ok_r && ptr_r == 8'h00
		|=> reg_rdata == {24'h000000, DFV_HDR_BYTES + {1'b0, cnt_r, 1'b0}})
		else $error("string length byte wrong");
	a_str_type: assert property (dat_rd && ok_r && ptr_r == 8'h01
		|=> reg_rdata == {24'h000000, DFV_TYPE_STRING})
		else $error("string type byte wrong");
	a_nodesc_zero: assert property (dat_rd && !ok_r |=> reg_rdata == 32'h0)
		else $error("descriptor given without strings");
	c_scan: cover property (start_ok);
	c_err: cover property ($rose(err_flag));
	c_str: cover property (dat_rd && ok_r);
endmodule

bind dfv_validator dfv_checker u_chk (
	.core_clk(core_clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.err_flag(err_flag),
	.scan_busy(scan_busy)
);

/* tb/dfv_host_model.sv */
// Host side: masters the register port and fetches descriptors.
// Assumes tasks are called only after reset has been released.
`timescale 1ns/1ps
module dfv_host_model
	import dfv_pkg::*;
(
	input wire logic core_clk, // Core clock
	output logic [7:0] reg_addr, // Address
	output logic [31:0] reg_wdata, // Write data
	output logic reg_wr, // Write strobe
	output logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata // Read data
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle access; idle lines inverted so stale values never help
	task automatic acc(input logic [7:0] a, input logic [31:0] d,
		input logic w, output logic [31:0] q);
		// Pacing is fixed; descriptor interval fields never steer it
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(negedge core_clk);
		q = reg_rdata; // Data stand one cycle only
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(a, d, 1'b1, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		acc(a, 32'h0, 1'b0, q);
	endtask
	// Request names a language, then eight bytes are fetched in order
	task automatic get_desc(input logic [7:0] idx, input logic [5:0] cnt,
		input logic [15:0] lang, output logic [63:0] d);
		logic [31:0] q;
		wr(DFV_OFF_STR_REQ, {lang, 2'h0, cnt, idx});
		for (int i = 0; i < 8; i++) begin
			rd(DFV_OFF_STR_DATA, q);
			d[8*i+:8] = q[7:0];
		end
	endtask
endmodule

/* tb/dfv_validator_bench.sv */
// Self-checking bench: endpoint checks, feedback pairing, strings.
// Assumes the host model masters the bus and a 40 MHz core clock.
`timescale 1ns/1ps
module dfv_validator_bench
	import dfv_pkg::*;
;
	logic core_clk, rst, reg_wr, reg_rd, err_flag, scan_busy;
	logic [7:0] reg_addr; // Address
	logic [31:0] reg_wdata, reg_rdata; // Bus data
	int n_mismatch = 0; // Failed compares
	int compares = 0; // All compares
	dfv_validator dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .err_flag(err_flag), .scan_busy(scan_busy));
	dfv_host_model h (.core_clk(core_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Status: error bit, code and failing slot
	task automatic st(input logic e, input logic [4:0] c, input logic [2:0] s);
		logic [31:0] r;
		h.rd(DFV_OFF_STATUS, r);
		chk("status", {e, c, s}, {r[0], r[12:8], r[6:4]});
		chk("err_flag", e, err_flag);
	endtask
	task automatic slot(input logic [2:0] s, input logic [15:0] a, input logic [15:0] m);
		h.wr(DFV_OFF_EP_SEL, {29'h0, s});
		h.wr(DFV_OFF_EP_ATTR, {16'h0, a});
		h.wr(DFV_OFF_EP_MPS, {16'h0, m});
	endtask
	// Scan length is fixed at eight slots, so a fixed wait suffices
	task automatic scan(input logic [4:0] c, input logic [2:0] s);
		h.wr(DFV_OFF_CTRL, 32'h6);
		chk("scan_busy", 32'h1, {31'h0, scan_busy});
		repeat (12) @(posedge core_clk);
		chk("scan_busy", 32'h0, {31'h0, scan_busy});
		st(c != 5'h00, c, s);
	endtask
	// One high-speed OUT endpoint 1 per entry: attr, size word, code
	localparam logic [31:0] T [18] = '{32'h02004000, 32'h0A004003,
		32'hC2004001, 32'h31004002, 32'h15004004, 32'h01000009,
		32'h01040000, 32'h01040109, 32'h010A0009, 32'h010A0100,
		32'h0112AA09, 32'h0112AB00, 32'h011C0008, 32'h01204008,
		32'h030A0009, 32'h020A0000, 32'h21004000, 32'h11004000};
	task automatic t_attr;
		foreach (T[i]) begin
			slot(3'h0, {8'h61, T[i][31:24]}, T[i][23:8]);
			scan(T[i][4:0], 3'h0);
		end
	endtask
	task automatic t_pair;
		slot(3'h0, 16'h4205, 16'h0040); // Async OUT data, endpoint 2
		scan(DFV_E_FBDIR, 3'h0);
		slot(3'h1, 16'h4111, 16'h0040); // Feedback in same direction
		scan(DFV_E_FBDIR, 3'h0);
		slot(3'h1, 16'h5111, 16'h0040); // Feedback IN, endpoint 1
		scan(DFV_E_GROUP, 3'h0);
		slot(3'h2, 16'h4105, 16'h0040); // Group head, endpoint 1
		scan(5'h00, 3'h0);
		slot(3'h3, 16'h5311, 16'h0040); // Higher feedback, endpoint 3
		scan(5'h00, 3'h0);
		slot(3'h0, 16'h4405, 16'h0040); // Endpoint 4 now finds 3
		scan(DFV_E_GROUP, 3'h0);
	endtask
	task automatic t_str;
		logic [63:0] d;
		logic [31:0] r;
		h.wr(DFV_OFF_CTRL, 32'h25); // Strings on, two languages
		h.wr(DFV_OFF_WORD, 32'h00000409);
		h.wr(DFV_OFF_WORD, 32'h00010407);
		h.get_desc(8'h00, 6'h00, 16'h0000, d);
		chk("lang list lo", 32'h04090306, d[31:0]);
		chk("lang list hi", 32'h00000407, d[63:32]);
		h.get_desc(8'h03, 6'h01, 16'h0409, d);
		chk("string lo", 32'h04090304, d[31:0]);
		chk("string hi", 32'h00000000, d[63:32]);
		h.wr(DFV_OFF_IDX_CHK, 32'h05);
		st(1'b0, 5'h00, 3'h0);
		h.wr(DFV_OFF_CTRL, 32'h04); // Strings off
		h.wr(DFV_OFF_IDX_CHK, 32'h00);
		st(1'b0, 5'h00, 3'h0);
		h.wr(DFV_OFF_IDX_CHK, 32'h05);
		st(1'b1, DFV_E_STRIDX, 3'h0);
		h.get_desc(8'h00, 6'h00, 16'h0409, d);
		chk("no desc lo", 32'h0, d[31:0]);
		chk("no desc hi", 32'h0, d[63:32]);
		h.rd(DFV_OFF_STATUS, r);
		chk("nodesc", 32'h1, {31'h0, r[DFV_ST_NODESC]});
		h.wr(DFV_OFF_CTRL, 32'h04);
		h.wr(DFV_OFF_EXT_HDR, 32'h02);
		st(1'b0, 5'h00, 3'h0);
		h.wr(DFV_OFF_EXT_HDR, 32'h01);
		st(1'b1, DFV_E_EXTLEN, 3'h0);
		h.rd(8'h3C, r);
		chk("unmapped", 32'h0, r);
	endtask
	initial begin
		#400us;
		n_mismatch++;
		end_sim();
	end
	initial begin
		rst = 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		st(1'b0, 5'h00, 3'h0);
		t_attr();
		t_pair();
		t_str();
		end_sim();
	end
endmodule
